// File: shared/dcbm_consts.vh
// Notes on behaviour
// - port A carries 36-bit words in, port B carries 36, 18 or 9 bits out.
// - almost-empty flag low while stored words are at or below its offset.
// - almost-full flag low while free locations are at or below its offset.
// - byte-order input sampled in reset: high sends most significant piece first.
// - after reset the same input picks timing: high standard, low fall-through.
// - bus-match high gives byte or word port B width by size, low full width.
// - port A clock times port A transfers and the fill-side flags.
// - port B clock times port B transfers and the drain-side flags.
// - port A moves data only with its select low; select high floats port A.
// - port B moves data only with its select low; select high floats port B.
// - in standard timing the drain status shows whether memory is empty.
// - in fall-through timing the drain status shows valid data on port B.
// - port A transfer also needs its transfer gate high at the edge.
// - port B transfer also needs its transfer gate high at the edge.
// - fill status shows not-full in both timings, high while space is left, on port A clock.
// - flags pass two stages on their own port clock.
`ifndef DCBM_CONSTS_VH
`define DCBM_CONSTS_VH

`define DCBM_WIDTH 36
`define DCBM_DEPTH 9'h100
`define DCBM_AW 8
`define DCBM_CW 9
`define DCBM_HALF_W 18
`define DCBM_BYTE_W 9
`define DCBM_PTR_ONE 8'h01
`define DCBM_CNT_ONE 9'h001
`define DCBM_CNT_ZERO 9'h000
`define DCBM_IDX_ZERO 2'h0
`define DCBM_IDX_ONE 2'h1
`define DCBM_LAST_LONG 2'h0
`define DCBM_LAST_WORD 2'h1
`define DCBM_LAST_BYTE 2'h3
`define DCBM_DATA_ZERO 36'h000000000
`define DCBM_PAD_WORD 18'h00000
`define DCBM_PAD_BYTE 27'h0000000

`endif

// File: core/dcbm_flag_stage.v
`timescale 1ns/1ns
// two flops advanced only on the owning port clock edge
module dcbm_flag_stage #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire nrst,
    input wire adv,
    input wire din,
    output reg dout
);
    reg first_q;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_q <= RESET_VAL;
            dout <= RESET_VAL;
        end else if (adv) begin
            first_q <= din;
            dout <= first_q;
        end
    end
endmodule // dcbm_flag_stage

// File: core/dcbm_fifo_top.v
`timescale 1ns/1ns
`include "dcbm_consts.vh"
module dcbm_fifo_top (
    input wire clk,
    input wire nrst,
    input wire write_port_clock,
    input wire read_port_clock,
    input wire write_port_select_n,
    input wire read_port_select_n,
    input wire port_a_xfer_gate,
    input wire port_b_xfer_gate,
    input wire byte_order_timing_select,
    input wire bus_width_match_sel,
    input wire bus_size_sel,
    input wire [`DCBM_CW-1:0] almost_empty_offset,
    input wire [`DCBM_CW-1:0] almost_full_offset,
    input wire [`DCBM_WIDTH-1:0] write_side_data_bus_i,
    output reg [`DCBM_WIDTH-1:0] write_side_data_bus_o,
    output reg write_side_data_bus_oe,
    input wire [`DCBM_WIDTH-1:0] read_side_data_bus_i,
    output reg [`DCBM_WIDTH-1:0] read_side_data_bus_o,
    output reg read_side_data_bus_oe,
    output wire drain_side_status_flag,
    output wire fill_side_status_flag,
    output wire almost_empty_flag_n,
    output wire almost_full_flag_n
);
    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    reg [`DCBM_WIDTH-1:0] mem_q [0:`DCBM_DEPTH-1];
    reg [`DCBM_AW-1:0] wr_ptr_q;
    reg [`DCBM_AW-1:0] rd_ptr_q;
    reg [`DCBM_CW-1:0] cnt_q;
    reg [`DCBM_CW-1:0] cnt_d;
    reg [1:0] idx_q;
    reg out_valid_q;
    reg wclk_q;
    reg rclk_q;
    reg big_endian_q;
    reg std_mode_q;
    reg bm_q;
    reg size_q;
    reg cfg_done_q;
    wire wclk_rise;
    wire rclk_rise;
    wire full;
    wire empty;
    wire wr_en;
    wire rd_en;
    wire [1:0] last_idx;
    wire last_piece;
    wire pop;
    wire [`DCBM_CW-1:0] free_cnt;
    wire [`DCBM_AW-1:0] rd_next;
    integer i;

    // ------------------------------------------------------------
    // piece selection for bus sizing and byte order
    // ------------------------------------------------------------
    function [`DCBM_WIDTH-1:0] piece;
        input [`DCBM_WIDTH-1:0] word;
        input [1:0] idx;
        input big;
        input bm;
        input size;
        reg [1:0] pos;
        begin
            pos = idx;
            piece = word;
            if (bm && !size) begin
                pos = big ? (`DCBM_IDX_ONE - idx) : idx;
                piece = {`DCBM_PAD_WORD, word[pos[0]*`DCBM_HALF_W +: `DCBM_HALF_W]};
            end else if (bm) begin
                pos = big ? (`DCBM_LAST_BYTE - idx) : idx;
                piece = {`DCBM_PAD_BYTE, word[pos*`DCBM_BYTE_W +: `DCBM_BYTE_W]};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // port clock edges and configuration
    // ------------------------------------------------------------
    assign wclk_rise = write_port_clock & ~wclk_q;
    assign rclk_rise = read_port_clock & ~rclk_q;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
        end else begin
            wclk_q <= write_port_clock;
            rclk_q <= read_port_clock;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            big_endian_q <= byte_order_timing_select;
            bm_q <= bus_width_match_sel;
            size_q <= bus_size_sel;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            std_mode_q <= 1'b1;
            cfg_done_q <= 1'b0;
        end else begin
            std_mode_q <= byte_order_timing_select;
            cfg_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // transfer qualification
    // ------------------------------------------------------------
    assign full = (cnt_q == `DCBM_DEPTH);
    assign empty = (cnt_q == `DCBM_CNT_ZERO);
    assign last_idx = !bm_q ? `DCBM_LAST_LONG : (size_q ? `DCBM_LAST_BYTE : `DCBM_LAST_WORD);
    assign last_piece = (idx_q == last_idx);
    assign wr_en = cfg_done_q & wclk_rise & ~write_port_select_n & port_a_xfer_gate & ~full;
    assign rd_en = cfg_done_q & rclk_rise & ~read_port_select_n & port_b_xfer_gate
                   & (std_mode_q ? ~empty : out_valid_q);
    assign pop = rd_en & last_piece;
    assign rd_next = rd_ptr_q + `DCBM_PTR_ONE;
    assign free_cnt = `DCBM_DEPTH - cnt_q;

    always @* begin
        cnt_d = cnt_q;
        if (wr_en && !pop) begin
            cnt_d = cnt_q + `DCBM_CNT_ONE;
        end else if (pop && !wr_en) begin
            cnt_d = cnt_q - `DCBM_CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // memory, pointers and port B output
    // ------------------------------------------------------------
    // 36-bit write store
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < `DCBM_DEPTH; i = i + 1) begin
                mem_q[i] <= `DCBM_DATA_ZERO;
            end
            wr_ptr_q <= {`DCBM_AW{1'b0}};
        end else if (wr_en) begin
            mem_q[wr_ptr_q] <= write_side_data_bus_i;
            wr_ptr_q <= wr_ptr_q + `DCBM_PTR_ONE;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr_q <= {`DCBM_AW{1'b0}};
            cnt_q <= `DCBM_CNT_ZERO;
            idx_q <= `DCBM_IDX_ZERO;
            out_valid_q <= 1'b0;
            read_side_data_bus_o <= `DCBM_DATA_ZERO;
        end else begin
            cnt_q <= cnt_d;
            if (rd_en) begin
                idx_q <= last_piece ? `DCBM_IDX_ZERO : idx_q + `DCBM_IDX_ONE;
            end
            if (pop) begin
                rd_ptr_q <= rd_next;
            end
            if (std_mode_q) begin
                // standard: a read strobe fetches the next piece
                out_valid_q <= 1'b0;
                if (rd_en) begin
                    read_side_data_bus_o <= piece(mem_q[rd_ptr_q], idx_q, big_endian_q,
                                                  bm_q, size_q);
                end
            end else if (rd_en && !last_piece) begin
                read_side_data_bus_o <= piece(mem_q[rd_ptr_q], idx_q + `DCBM_IDX_ONE,
                                              big_endian_q, bm_q, size_q);
            end else if (pop) begin
                out_valid_q <= (cnt_q > `DCBM_CNT_ONE);
                // last stored word read: old data stands, no stale location shown
                if (cnt_q > `DCBM_CNT_ONE) begin
                    read_side_data_bus_o <= piece(mem_q[rd_next], `DCBM_IDX_ZERO,
                                                  big_endian_q, bm_q, size_q);
                end
            end else if (!out_valid_q && !empty && rclk_rise) begin
                out_valid_q <= 1'b1;
                read_side_data_bus_o <= piece(mem_q[rd_ptr_q], idx_q, big_endian_q,
                                              bm_q, size_q);
            end
        end
    end

    // ------------------------------------------------------------
    // output enables
    // ------------------------------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            write_side_data_bus_o <= `DCBM_DATA_ZERO;
            write_side_data_bus_oe <= 1'b0;
            read_side_data_bus_oe <= 1'b0;
        end else begin
            write_side_data_bus_o <= `DCBM_DATA_ZERO;
            write_side_data_bus_oe <= 1'b0;
            read_side_data_bus_oe <= ~read_port_select_n;
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    // drain status
    dcbm_flag_stage #(.RESET_VAL(1'b0)) u_drain (
        .clk(clk),
        .nrst(nrst),
        .adv(rclk_rise),
        .din(std_mode_q ? ~empty : out_valid_q),
        .dout(drain_side_status_flag)
    );

    dcbm_flag_stage #(.RESET_VAL(1'b0)) u_fill (
        .clk(clk),
        .nrst(nrst),
        .adv(wclk_rise),
        .din(cfg_done_q & ~full),
        .dout(fill_side_status_flag)
    );

    dcbm_flag_stage #(.RESET_VAL(1'b0)) u_aempty (
        .clk(clk),
        .nrst(nrst),
        .adv(rclk_rise),
        .din(cnt_q > almost_empty_offset),
        .dout(almost_empty_flag_n)
    );

    dcbm_flag_stage #(.RESET_VAL(1'b1)) u_afull (
        .clk(clk),
        .nrst(nrst),
        .adv(wclk_rise),
        .din(free_cnt > almost_full_offset),
        .dout(almost_full_flag_n)
    );
endmodule // dcbm_fifo_top

// File: testbench/dcbm_fifo_monitor.sv
`timescale 1ns/1ns
module dcbm_fifo_monitor (
    input wire clk,
    input wire nrst,
    input wire write_port_clock,
    input wire read_port_clock,
    input wire write_port_select_n,
    input wire read_port_select_n,
    input wire port_a_xfer_gate,
    input wire port_b_xfer_gate,
    input wire byte_order_timing_select,
    input wire [35:0] write_side_data_bus_o,
    input wire write_side_data_bus_oe,
    input wire read_side_data_bus_oe,
    input wire drain_side_status_flag,
    input wire fill_side_status_flag,
    input wire almost_empty_flag_n,
    input wire almost_full_flag_n
);
    reg a_q, b_q, a_rise_q, b_rise_q;
    // ----------------------------------------
    // port clock rise seen one clk late
    // ----------------------------------------
    always @(posedge clk) begin
        a_q <= write_port_clock;
        b_q <= read_port_clock;
        a_rise_q <= write_port_clock & ~a_q;
        b_rise_q <= read_port_clock & ~b_q;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wr_bus_float_a: assert property (!write_side_data_bus_oe)
        else $error("port a bus driven");
    wr_bus_zero_a: assert property (write_side_data_bus_o == 36'h0)
        else $error("port a data not idle");
    rd_sel_float_a: assert property (read_port_select_n |=> !read_side_data_bus_oe)
        else $error("port b driven while deselected");
    rd_sel_drive_a: assert property (!read_port_select_n |=> read_side_data_bus_oe)
        else $error("port b not driven while selected");
    drain_sync_a: assert property ($changed(drain_side_status_flag) |-> b_rise_q)
        else $error("drain flag moved off port b edge");
    aempty_sync_a: assert property ($changed(almost_empty_flag_n) |-> b_rise_q)
        else $error("almost empty moved off port b edge");
    fill_sync_a: assert property ($changed(fill_side_status_flag) |-> a_rise_q)
        else $error("fill flag moved off port a edge");
    afull_sync_a: assert property ($changed(almost_full_flag_n) |-> a_rise_q)
        else $error("almost full moved off port a edge");
    empty_then_low_a: assert property (byte_order_timing_select && !drain_side_status_flag
        |-> !almost_empty_flag_n)
        else $error("empty but almost empty high");
    cover property ($rose(write_port_clock) && !write_port_select_n && port_a_xfer_gate);
    cover property ($rose(read_port_clock) && !read_port_select_n && port_b_xfer_gate);
    cover property ($fell(fill_side_status_flag));
    cover property ($rose(drain_side_status_flag));
endmodule // dcbm_fifo_monitor
bind dcbm_fifo_top dcbm_fifo_monitor mon_u (.clk(clk), .nrst(nrst),
    .write_port_clock(write_port_clock), .read_port_clock(read_port_clock),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .port_a_xfer_gate(port_a_xfer_gate), .port_b_xfer_gate(port_b_xfer_gate),
    .byte_order_timing_select(byte_order_timing_select),
    .write_side_data_bus_o(write_side_data_bus_o),
    .write_side_data_bus_oe(write_side_data_bus_oe),
    .read_side_data_bus_oe(read_side_data_bus_oe),
    .drain_side_status_flag(drain_side_status_flag),
    .fill_side_status_flag(fill_side_status_flag),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));

// File: testbench/dcbm_reader_model.sv
`timescale 1ns/1ns
// port b processor, reads with random stalls
module dcbm_reader_model (
    input wire clk,
    input wire rd_en,
    output reg read_port_clock,
    output reg read_port_select_n,
    output reg port_b_xfer_gate,
    output reg [35:0] read_side_data_bus_i
);
    reg ph;
    initial begin
        ph = 1'h0;
        read_port_clock = 1'h0;
        read_port_select_n = 1'h1;
        port_b_xfer_gate = 1'h0;
        read_side_data_bus_i = 36'h0;
    end
    // free clock, controls move while clock low
    always @(posedge clk) begin
        #1 ph = ~ph;
        read_side_data_bus_i = ~read_side_data_bus_i;
        if (ph) begin
            read_port_clock = ~read_port_clock;
            if (!read_port_clock) begin
                read_port_select_n = ~rd_en;
                port_b_xfer_gate = rd_en && ($urandom % 4 != 0);
            end
        end
    end
endmodule // dcbm_reader_model

// File: testbench/dual_clock_bus_matching_fifo_ports_tb_top.sv
`timescale 1ns/1ns
`include "dcbm_consts.vh"
module dual_clock_bus_matching_fifo_ports_tb_top;
    reg clk, nrst, wck, sel_n, gate, bots, bm, sz, big, std, rd_en;
    reg [8:0] x_off, y_off;
    reg [35:0] wd, prev;
    reg [3:0] cfg [0:5];
    reg [35:0] exp_q [$];
    wire [35:0] rd_o, rd_i;
    wire rck, rsel_n, rgate, ef, ff, ae_n, af_n;
    integer miscompares, n_checks, cyc, i, k, n, n0;
    dcbm_fifo_top dut_u (.clk(clk), .nrst(nrst), .write_port_clock(wck),
        .read_port_clock(rck), .write_port_select_n(sel_n), .read_port_select_n(rsel_n),
        .port_a_xfer_gate(gate), .port_b_xfer_gate(rgate), .byte_order_timing_select(bots),
        .bus_width_match_sel(bm), .bus_size_sel(sz), .almost_empty_offset(x_off),
        .almost_full_offset(y_off), .write_side_data_bus_i(wd), .write_side_data_bus_o(),
        .write_side_data_bus_oe(), .read_side_data_bus_i(rd_i), .read_side_data_bus_o(rd_o),
        .read_side_data_bus_oe(), .drain_side_status_flag(ef), .fill_side_status_flag(ff),
        .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n));
    dcbm_reader_model bmod_u (.clk(clk), .rd_en(rd_en), .read_port_clock(rck),
        .read_port_select_n(rsel_n), .port_b_xfer_gate(rgate), .read_side_data_bus_i(rd_i));
    task chk(input [35:0] seen, input [35:0] expv);
        begin
            n_checks = n_checks + 1;
            if (seen !== expv) begin
                miscompares = miscompares + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d miscompares=%0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // one port a transfer, pieces noted in order
    task automatic wr(input s_n, input g, input keep);
        integer j, np, pw;
        begin
            n = n + 1;
            wd = {2'h3, 7'($urandom), 2'h2, 7'($urandom), 2'h1, 7'($urandom), 2'h0, n[6:0]};
            @(posedge clk);
            while (wck !== 1'h0) @(posedge clk);
            #1 sel_n = s_n;
            gate = g;
            @(posedge clk);
            #1 gate = 1'h0;
            np = !bm ? 1 : sz ? 4 : 2;
            pw = 36 / np;
            for (j = 0; keep && j < np; j = j + 1)
                exp_q.push_back((wd >> (pw * (big ? np - 1 - j : j))) & (36'hFFFFFFFFF >> (36 - pw)));
        end
    endtask
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // port a clock and run limit
    // ----------------------------------------
    always @(posedge clk) begin
        #1 wck = ~wck;
        cyc = cyc + 1;
        if (cyc == 40000) begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end
    // ----------------------------------------
    // watcher: each new port b value is one piece
    // ----------------------------------------
    always @(posedge clk) begin
        if (nrst && rd_o !== prev) begin
            if (exp_q.size() == 0)
                chk(rd_o, ~rd_o);
            else
                chk(rd_o, exp_q.pop_front());
        end
        prev = rd_o;
    end
    initial begin
        {nrst, wck, sel_n, gate, bots, bm, sz, rd_en} = 8'h20;
        {x_off, y_off, wd, prev} = 90'h0;
        {miscompares, n_checks, cyc, n} = 128'h0;
        k = $urandom(39);
        // big, standard, match, byte
        {cfg[0], cfg[1], cfg[2], cfg[3], cfg[4], cfg[5]} = 24'hC0E2B7;
        for (i = 0; i < 6; i = i + 1) begin
            {big, std, bm, sz} = cfg[i];
            nrst = 1'h0;
            bots = big;
            x_off = 9'($urandom % 8);
            y_off = 9'($urandom % 8);
            repeat (6) @(posedge clk);
            #1 nrst = 1'h1;
            bots = std;
            n0 = 4 + $urandom % 8;
            wr(1'h1, 1'h1, 1'h0);
            wr(1'h0, 1'h0, 1'h0);
            repeat (n0) wr(1'h0, 1'h1, 1'h1);
            repeat (30) @(posedge clk);
            chk(ae_n, n0 > x_off);
            chk(ef, 1'h1);
            chk(af_n, 1'h1);
            for (k = n0; i < 2 && k <= 256; k = k + 1)
                wr(1'h0, 1'h1, k < 256);
            repeat (30) @(posedge clk);
            chk(ff, i >= 2);
            chk(af_n, i >= 2);
            #1 rd_en = 1'h1;
            // a full fifo must drain a little before noted writes go in
            while (exp_q.size() > 240) @(posedge clk);
            repeat (6) wr(1'h0, 1'h1, 1'h1);
            while (exp_q.size() != 0) @(posedge clk);
            repeat (40) @(posedge clk);
            #1 rd_en = 1'h0;
            chk(ef, 1'h0);
            chk(ae_n, 1'h0);
            chk(ff, 1'h1);
        end
        print_verdict;
    end
endmodule // dual_clock_bus_matching_fifo_ports_tb_top
